// >>> src/pd_rx_event_pkg.sv
// constants, field positions and carriers for the receive event status block
package pd_rx_event_pkg;
  // register map (byte addresses on the plain register port)
  localparam logic [15:0] ADDR_EVENT_STATUS = 16'h1a82;
  localparam logic [15:0] ADDR_ERROR_STATUS = 16'h1a83;
  localparam logic [15:0] ADDR_EVENT_ENABLE = 16'h1a87;
  localparam logic [15:0] ADDR_ERROR_ENABLE = 16'h1a88;
  localparam logic [15:0] ADDR_SOP_TYPE_ENABLE = 16'h1a90;
  // event status field positions
  localparam int EV_FIFO_PENDING = 7;
  localparam int EV_BUS_IDLE = 6;
  localparam int EV_CABLE_RESET = 5;
  localparam int EV_HARD_RESET = 3;
  localparam int EV_FRAME_END = 2;
  localparam int EV_FRAME_START = 1;
  localparam int EV_RX_DONE = 0;
  // error status field positions
  localparam int ER_COUNTER_LIMIT = 7;
  localparam int ER_CORRUPT = 3;
  localparam int ER_OVERRUN = 2;
  localparam int ER_PROTOCOL = 1;
  localparam int ER_DISCARDED = 0;
  // writable masks and reset values
  localparam logic [7:0] EVENT_W1C_MASK = 8'h6f;
  localparam logic [7:0] ERROR_W1C_MASK = 8'h8f;
  localparam logic [7:0] EVENT_ENABLE_MASK = 8'hef;
  localparam logic [7:0] EVENT_RESET = 8'h40;
  localparam logic [7:0] ERROR_RESET = 8'h00;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam int SOP_TYPES = 5;
  localparam logic [SOP_TYPES-1:0] SOP_ENABLE_RESET = 5'h1f;
  // corrupt cause vector positions
  localparam int CAUSE_BAD_CRC = 0;
  localparam int CAUSE_SYMBOL = 1;
  localparam int CAUSE_OVERSIZE = 2;
  localparam int CAUSE_ODD_NIBBLE = 3;

  // one received message as reported by the receiver
  typedef struct packed {
    logic done;       // one-cycle pulse: message fully received with good crc
    logic isGoodCrc;  // message is a goodcrc
    logic isPing;     // message is a ping
    logic duplicate;  // message id repeats the last one
  } rxMsg_s;

  // operating modes of the mac
  typedef struct packed {
    logic autoRetry;        // automatic retry active
    logic autoResponse;     // automatic goodcrc response active
    logic goodCrcExpected;  // a goodcrc is awaited for our transmit
  } macMode_s;

  // frame tracking between start and end of a packet
  typedef enum logic [1:0] {
    FRAME_IDLE = 2'b00,
    FRAME_ENABLED = 2'b01,
    FRAME_DISABLED = 2'b10
  } frame_e;
endpackage : pd_rx_event_pkg

// >>> src/pd_rx_event_status.sv
// receive event and receive error status registers with interrupt request
// Behaviour
// R1 - event bit 7 is read-only, high exactly while receive fifo holds data
// R2 - event bit 6 sets when bus shows no activity; resets to one
// R3 - idle bit is an event: sets on enable when idle, else on idle
// R4 - idle events are produced only while mac clocks run
// R5 - event bit 5 sets when a cable reset message is received
// R6 - event bit 3 sets on hard reset; bit 4 reserved, reads zero
// R7 - event bit 2 sets on valid end framing; bad ending discards the packet
// R8 - end event only for frames whose start type is enabled
// R9 - event bit 1 sets on valid start framing of an enabled type
// R10 - event bit 0 sets on good receive; expected goodcrc in retry excluded
// R11 - in auto response duplicates are discarded without receive-done; a duplicate that is also a protocol error here is queued with receive-done
// R12 - in auto response receive-done sets before the goodcrc reply starts
// R13 - hardware sets event bits; writing one clears, zero leaves them
// R14 - enables gate only the interrupt, status records events regardless; idle bit 6 here sets only while its enable is set
// R15 - error bit 7 sets when bad crc or duplicate counter hits limit
// R16 - counter limit bit is persistent; sets again while condition holds
// R17 - error bit 3 on corrupt packet; matching packet status flag set too
// R18 - error bit 2 on packet with no buffer space; flag full, discard
// R19 - error bit 1 on unexpected message awaiting goodcrc; abort retry
// R20 - on protocol error message is still queued and receive-done set
// R21 - error bit 0 on discarded packet; bits 6 to 4 reserved, read zero
// R22 - all interrupt enables are zero after reset
// R23 - interrupt is or of every status bit and its enable
`timescale 1ns/1ns
module pd_rx_event_status (
  input wire logic clk_sys, // system clock 100 MHz
  input wire logic rst_n, // async reset, active low
  input wire logic [15:0] regAddr, // register address
  input wire logic [7:0] regWdata, // register write data
  input wire logic regWr, // write strobe
  input wire logic regRd, // read strobe
  output logic [7:0] regRdata, // read data, cycle after strobe
  input wire logic fifoNotEmpty, // receive fifo holds unread data
  input wire logic lineIdle, // no activity on the bus
  input wire logic clocksRunning, // mac clocks enabled
  input wire logic cableResetRx, // pulse: cable reset received
  input wire logic hardResetRx, // pulse: hard reset received
  input wire logic sopSeen, // pulse: valid start framing
  input wire logic [2:0] sopType, // start type index of sopSeen
  input wire logic eopGood, // pulse: valid end framing
  input wire logic eopBad, // pulse: bad end or abnormal stop
  input wire pd_rx_event_pkg::rxMsg_s rxMsg, // received message report
  input wire pd_rx_event_pkg::macMode_s macMode, // mac operating modes
  input wire logic badCrcLimit, // bad crc counter at limit
  input wire logic dupLimit, // duplicate counter at limit
  input wire logic corruptPkt, // pulse: corrupt packet
  input wire logic [3:0] corruptCause, // cause bits of corruptPkt
  input wire logic pktArrive, // pulse: packet begins storing
  input wire logic bufferFull, // no buffer space at pktArrive
  output logic discardPkt, // pulse: drop current packet
  output logic storePkt, // pulse: keep message in receive queue
  output logic replyStart, // pulse: start automatic goodcrc
  output logic retryAbort, // pulse: abort retry, flag transmit aborted
  output logic [3:0] pktStatusSet, // pulse: packet status flags to set
  output logic fifoFullSet, // pulse: fifo-full packet status flag
  output logic irq // interrupt request, active high
);

  logic [7:0] eventStat_q;
  logic [7:0] eventStat_d;
  logic [7:0] errorStat_q;
  logic [7:0] errorStat_d;
  logic [7:0] eventEn_q;
  logic [7:0] errorEn_q;
  logic [pd_rx_event_pkg::SOP_TYPES-1:0] sopEn_q;
  logic [7:0] eventSet;
  logic [7:0] errorSet;
  logic [7:0] eventClr;
  logic [7:0] errorClr;
  logic [7:0] eventView;
  logic idleArm;
  logic idleArm_q;
  logic sopTypeOk;
  pd_rx_event_pkg::frame_e frame_q;
  logic dropMsg;
  logic protoErr;
  logic acceptMsg;

  // register write decode
  always_comb
  begin
    eventClr = 8'h00;
    errorClr = 8'h00;
    if (regWr && regAddr == pd_rx_event_pkg::ADDR_EVENT_STATUS)
    begin
      eventClr = regWdata & pd_rx_event_pkg::EVENT_W1C_MASK; // see R13
    end
    if (regWr && regAddr == pd_rx_event_pkg::ADDR_ERROR_STATUS)
    begin
      errorClr = regWdata & pd_rx_event_pkg::ERROR_W1C_MASK; // see R13
    end
  end

  // enable registers
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      eventEn_q <= pd_rx_event_pkg::ENABLE_RESET; // see R22
      errorEn_q <= pd_rx_event_pkg::ENABLE_RESET; // see R22
    end
    else if (regWr)
    begin
      if (regAddr == pd_rx_event_pkg::ADDR_EVENT_ENABLE)
      begin
        eventEn_q <= regWdata & pd_rx_event_pkg::EVENT_ENABLE_MASK; // see R14
      end
      if (regAddr == pd_rx_event_pkg::ADDR_ERROR_ENABLE)
      begin
        errorEn_q <= regWdata & pd_rx_event_pkg::ERROR_W1C_MASK;
      end
    end
  end

  // start type enable register
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sopEn_q <= pd_rx_event_pkg::SOP_ENABLE_RESET;
    end
    else if (regWr && regAddr == pd_rx_event_pkg::ADDR_SOP_TYPE_ENABLE)
    begin
      sopEn_q <= regWdata[pd_rx_event_pkg::SOP_TYPES-1:0];
    end
  end

  // idle event arms only while enabled, idle and clocked
  assign idleArm = eventEn_q[pd_rx_event_pkg::EV_BUS_IDLE] && lineIdle && clocksRunning; // see R3, R4

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      idleArm_q <= 1'b0;
    end
    else
    begin
      idleArm_q <= idleArm;
    end
  end

  // start type check
  assign sopTypeOk = (sopType < 3'(pd_rx_event_pkg::SOP_TYPES)) && sopEn_q[sopType[2:0]];

  // frame tracking from start to end
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      frame_q <= pd_rx_event_pkg::FRAME_IDLE;
    end
    else
    begin
      case (frame_q)
        pd_rx_event_pkg::FRAME_IDLE:
        begin
          if (sopSeen)
          begin
            frame_q <= sopTypeOk ? pd_rx_event_pkg::FRAME_ENABLED : pd_rx_event_pkg::FRAME_DISABLED;
          end
        end
        pd_rx_event_pkg::FRAME_ENABLED, pd_rx_event_pkg::FRAME_DISABLED:
        begin
          if (eopGood || eopBad)
          begin
            frame_q <= pd_rx_event_pkg::FRAME_IDLE;
          end
        end
        default:
        begin
          frame_q <= pd_rx_event_pkg::FRAME_IDLE;
        end
      endcase
    end
  end

  // message classification
  assign dropMsg = rxMsg.done && ((macMode.autoRetry && macMode.goodCrcExpected && rxMsg.isGoodCrc) // see R10
    || (macMode.autoResponse && rxMsg.duplicate && !protoErr)); // see R11, R20
  assign protoErr = rxMsg.done && macMode.autoRetry && macMode.goodCrcExpected
    && !rxMsg.isGoodCrc && !rxMsg.isPing; // see R19
  assign acceptMsg = rxMsg.done && !dropMsg; // see R20

  // event set sources
  always_comb
  begin
    eventSet = 8'h00;
    eventSet[pd_rx_event_pkg::EV_BUS_IDLE] = idleArm && !idleArm_q; // see R2, R3
    eventSet[pd_rx_event_pkg::EV_CABLE_RESET] = cableResetRx; // see R5
    eventSet[pd_rx_event_pkg::EV_HARD_RESET] = hardResetRx; // see R6
    eventSet[pd_rx_event_pkg::EV_FRAME_END] = eopGood && frame_q == pd_rx_event_pkg::FRAME_ENABLED; // see R7, R8
    eventSet[pd_rx_event_pkg::EV_FRAME_START] = sopSeen && sopTypeOk; // see R9
    eventSet[pd_rx_event_pkg::EV_RX_DONE] = acceptMsg; // see R10, R20
  end

  // error set sources
  always_comb
  begin
    errorSet = 8'h00;
    errorSet[pd_rx_event_pkg::ER_COUNTER_LIMIT] = badCrcLimit || dupLimit; // see R15, R16
    errorSet[pd_rx_event_pkg::ER_CORRUPT] = corruptPkt; // see R17
    errorSet[pd_rx_event_pkg::ER_OVERRUN] = pktArrive && bufferFull; // see R18
    errorSet[pd_rx_event_pkg::ER_PROTOCOL] = protoErr; // see R19
    errorSet[pd_rx_event_pkg::ER_DISCARDED] = dropMsg; // see R21
  end

  // sticky status, set wins over clear
  assign eventStat_d = ((eventStat_q & ~eventClr) | eventSet) & pd_rx_event_pkg::EVENT_W1C_MASK; // see R13, R6
  assign errorStat_d = ((errorStat_q & ~errorClr) | errorSet) & pd_rx_event_pkg::ERROR_W1C_MASK; // see R21

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      eventStat_q <= pd_rx_event_pkg::EVENT_RESET; // see R2
      errorStat_q <= pd_rx_event_pkg::ERROR_RESET;
    end
    else
    begin
      eventStat_q <= eventStat_d; // see R14
      errorStat_q <= errorStat_d; // see R14
    end
  end

  // event view with live fifo level in bit 7
  always_comb
  begin
    eventView = eventStat_q;
    eventView[pd_rx_event_pkg::EV_FIFO_PENDING] = fifoNotEmpty; // see R1
  end

  // read data one cycle after the strobe
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      regRdata <= 8'h00;
    end
    else if (regRd)
    begin
      case (regAddr)
        pd_rx_event_pkg::ADDR_EVENT_STATUS: regRdata <= eventView;
        pd_rx_event_pkg::ADDR_ERROR_STATUS: regRdata <= errorStat_q;
        pd_rx_event_pkg::ADDR_EVENT_ENABLE: regRdata <= eventEn_q;
        pd_rx_event_pkg::ADDR_ERROR_ENABLE: regRdata <= errorEn_q;
        pd_rx_event_pkg::ADDR_SOP_TYPE_ENABLE: regRdata <= {3'h0, sopEn_q};
        default: regRdata <= 8'h00;
      endcase
    end
    else
    begin
      regRdata <= 8'h00;
    end
  end

  // commands back to the mac, one cycle after their cause
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      discardPkt <= 1'b0;
      storePkt <= 1'b0;
      replyStart <= 1'b0;
      retryAbort <= 1'b0;
      pktStatusSet <= 4'h0;
      fifoFullSet <= 1'b0;
    end
    else
    begin
      discardPkt <= dropMsg || eopBad || (pktArrive && bufferFull); // see R7, R18, R21
      storePkt <= acceptMsg; // see R20
      replyStart <= acceptMsg && macMode.autoResponse; // see R12
      retryAbort <= protoErr; // see R19
      pktStatusSet <= corruptPkt ? corruptCause : 4'h0; // see R17
      fifoFullSet <= pktArrive && bufferFull; // see R18
    end
  end

  // interrupt request from enabled status bits
  assign irq = |(eventView & eventEn_q) || |(errorStat_q & errorEn_q); // see R14, R23

  // checks
  property p_fifoPending; // see R1
    @(posedge clk_sys) disable iff (!rst_n)
      regRd && regAddr == pd_rx_event_pkg::ADDR_EVENT_STATUS
        |=> regRdata[pd_rx_event_pkg::EV_FIFO_PENDING] == $past(fifoNotEmpty);
  endproperty
  a_fifoPending: assert property (p_fifoPending) else $error("fifo pending bit wrong"); // see R1

  property p_idleStopped; // see R4
    @(posedge clk_sys) disable iff (!rst_n)
      !clocksRunning && !eventStat_q[pd_rx_event_pkg::EV_BUS_IDLE] && !eventClr[pd_rx_event_pkg::EV_BUS_IDLE]
        |=> !eventStat_q[pd_rx_event_pkg::EV_BUS_IDLE];
  endproperty
  a_idleStopped: assert property (p_idleStopped) else $error("idle event without clocks"); // see R4

  property p_idleRise; // see R3
    @(posedge clk_sys) disable iff (!rst_n)
      $rose(idleArm) |-> ##1 eventStat_q[pd_rx_event_pkg::EV_BUS_IDLE];
  endproperty
  a_idleRise: assert property (p_idleRise) else $error("idle event missed"); // see R3

  property p_eopGate; // see R8
    @(posedge clk_sys) disable iff (!rst_n)
      eopGood && frame_q != pd_rx_event_pkg::FRAME_ENABLED && !eventStat_q[pd_rx_event_pkg::EV_FRAME_END]
        |=> !eventStat_q[pd_rx_event_pkg::EV_FRAME_END];
  endproperty
  a_eopGate: assert property (p_eopGate) else $error("end event for disabled frame"); // see R8

  property p_setWins; // see R13
    @(posedge clk_sys) disable iff (!rst_n)
      cableResetRx && eventClr[pd_rx_event_pkg::EV_CABLE_RESET] |=> eventStat_q[pd_rx_event_pkg::EV_CABLE_RESET];
  endproperty
  a_setWins: assert property (p_setWins) else $error("clear beat set"); // see R13

  property p_clearOne; // see R13
    @(posedge clk_sys) disable iff (!rst_n)
      eventClr[pd_rx_event_pkg::EV_HARD_RESET] && !hardResetRx |=> !eventStat_q[pd_rx_event_pkg::EV_HARD_RESET];
  endproperty
  a_clearOne: assert property (p_clearOne) else $error("write one did not clear"); // see R13

  property p_dropNoDone; // see R11
    @(posedge clk_sys) disable iff (!rst_n)
      dropMsg |=> errorStat_q[pd_rx_event_pkg::ER_DISCARDED] && !storePkt && !replyStart;
  endproperty
  a_dropNoDone: assert property (p_dropNoDone) else $error("dropped message indicated"); // see R11

  property p_replyAfterDone; // see R12
    @(posedge clk_sys) disable iff (!rst_n)
      replyStart |-> eventStat_q[pd_rx_event_pkg::EV_RX_DONE] && $past(acceptMsg);
  endproperty
  a_replyAfterDone: assert property (p_replyAfterDone) else $error("reply before receive-done"); // see R12

  property p_persistent; // see R16
    @(posedge clk_sys) disable iff (!rst_n)
      (badCrcLimit || dupLimit) |=> errorStat_q[pd_rx_event_pkg::ER_COUNTER_LIMIT];
  endproperty
  a_persistent: assert property (p_persistent) else $error("limit bit not persistent"); // see R16

  property p_protocol; // see R19
    @(posedge clk_sys) disable iff (!rst_n)
      protoErr |=> retryAbort && storePkt && errorStat_q[pd_rx_event_pkg::ER_PROTOCOL]
        && eventStat_q[pd_rx_event_pkg::EV_RX_DONE];
  endproperty
  a_protocol: assert property (p_protocol) else $error("protocol error handling wrong"); // see R19

  property p_irq; // see R23
    @(posedge clk_sys) disable iff (!rst_n)
      (eventEn_q == 8'h00 && errorEn_q == 8'h00) |-> !irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt while all disabled"); // see R22

  property p_reserved; // see R21
    @(posedge clk_sys) disable iff (!rst_n)
      (errorStat_q & ~pd_rx_event_pkg::ERROR_W1C_MASK) == 8'h00
        && (eventStat_q & ~pd_rx_event_pkg::EVENT_W1C_MASK) == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set"); // see R6

endmodule : pd_rx_event_status

// >>> dv/pd_rx_mac_model.sv
// receive mac model that turns bench requests into event strobes of the status block
`timescale 1ns/1ns
module pd_rx_mac_model (
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic fireReq, // request: strobe the chosen events next cycle
  input wire logic [7:0] fireWhich, // events to strobe
  input wire logic [2:0] fireType, // start type reported with start framing
  output logic [7:0] evPulse, // event strobes, one cycle each
  output logic [2:0] sopType // start type standing beside the strobes
);
  // strobes rest low between requests, type follows the request side
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      evPulse <= 8'h00;
      sopType <= 3'h0;
    end
    else
    begin
      evPulse <= fireReq ? fireWhich : 8'h00;
      sopType <= fireType;
    end
  end
endmodule : pd_rx_mac_model

// >>> dv/pd_rx_event_status_bench.sv
// self-checking bench for the receive event status block
`timescale 1ns/1ns
module pd_rx_event_status_bench;
  localparam logic [15:0] EV = pd_rx_event_pkg::ADDR_EVENT_STATUS;
  localparam logic [15:0] ER = pd_rx_event_pkg::ADDR_ERROR_STATUS;
  localparam logic [15:0] EVEN = pd_rx_event_pkg::ADDR_EVENT_ENABLE;
  localparam logic [15:0] EREN = pd_rx_event_pkg::ADDR_ERROR_ENABLE;
  localparam logic [15:0] SOPEN = pd_rx_event_pkg::ADDR_SOP_TYPE_ENABLE;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] regAddr = 16'h0000;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdata;
  logic fifoNotEmpty = 1'b0;
  logic lineIdle = 1'b1;
  logic clocksRunning = 1'b1;
  logic [2:0] qual = 3'h0;
  pd_rx_event_pkg::macMode_s mode = 3'h0;
  logic badCrcLimit = 1'b0;
  logic dupLimit = 1'b0;
  logic [3:0] cause = 4'h0;
  logic bufferFull = 1'b0;
  logic [7:0] evPulse;
  logic fireReq = 1'b0;
  logic [7:0] fireWhich = 8'h00;
  logic [2:0] fireType = 3'h0;
  logic [2:0] sopType;
  pd_rx_event_pkg::rxMsg_s msg;
  logic discardPkt, storePkt, replyStart, retryAbort, fifoFullSet, irq;
  logic [3:0] pktStatusSet;
  logic [5:0] caseIn [6] = '{6'h00, 6'h2c, 6'h11, 6'h10, 6'h28, 6'h2a};
  logic [7:0] caseExp [6] = '{8'h41, 8'h82, 8'h82, 8'h61, 8'h55, 8'h41};
  int badCount = 0;
  int comparisons = 0;

  // free-running clock
  always #5 clk_sys = ~clk_sys;
  // done strobe joined with its qualifiers
  assign msg = {evPulse[5], qual};

  pd_rx_mac_model mac (
    .clk_sys(clk_sys), .rst_n(rst_n), .fireReq(fireReq), .fireWhich(fireWhich),
    .fireType(fireType), .evPulse(evPulse), .sopType(sopType)
  );

  pd_rx_event_status uut (
    .clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .fifoNotEmpty(fifoNotEmpty),
    .lineIdle(lineIdle), .clocksRunning(clocksRunning), .cableResetRx(evPulse[0]),
    .hardResetRx(evPulse[1]), .sopSeen(evPulse[2]), .sopType(sopType), .eopGood(evPulse[3]),
    .eopBad(evPulse[4]), .rxMsg(msg), .macMode(mode), .badCrcLimit(badCrcLimit),
    .dupLimit(dupLimit), .corruptPkt(evPulse[6]), .corruptCause(cause), .pktArrive(evPulse[7]),
    .bufferFull(bufferFull), .discardPkt(discardPkt), .storePkt(storePkt),
    .replyStart(replyStart), .retryAbort(retryAbort), .pktStatusSet(pktStatusSet),
    .fifoFullSet(fifoFullSet), .irq(irq)
  );

  // verdict and end of run
  task automatic endSim();
    $display("comparisons %0d mismatches %0d", comparisons, badCount);
    if (badCount == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : endSim

  // byte comparison with mismatch report
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      badCount++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one-cycle register write
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask : wr

  // one-cycle register read, data compared mid-cycle while it stands
  task automatic rdChk(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    @(negedge clk_sys);
    chk(regRdata, exp);
    @(posedge clk_sys);
  endtask : rdChk

  // one event request to the mac model; returns mid-cycle while command pulses stand
  task automatic fire(input logic [7:0] which);
    @(posedge clk_sys);
    fireReq <= 1'b1;
    fireWhich <= which;
    @(posedge clk_sys);
    fireReq <= 1'b0;
    @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : fire

  // hang guard
  initial
  begin
    #200000;
    badCount++;
    endSim();
  end

  // test sequence
  initial
  begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    rdChk(EV, pd_rx_event_pkg::EVENT_RESET);
    rdChk(ER, pd_rx_event_pkg::ERROR_RESET);
    rdChk(EVEN, 8'h00);
    rdChk(EREN, 8'h00);
    rdChk(SOPEN, {3'h0, pd_rx_event_pkg::SOP_ENABLE_RESET});
    rdChk(16'h1a84, 8'h00);
    chk({7'h0, irq}, 8'h00);
    $display("test reset done");
    wr(EV, 8'h00);
    rdChk(EV, 8'h40);
    wr(EV, 8'h40);
    rdChk(EV, 8'h00);
    fifoNotEmpty <= 1'b1;
    rdChk(EV, 8'h80);
    wr(EVEN, 8'h90);
    rdChk(EVEN, 8'h80);
    chk({7'h0, irq}, 8'h01);
    wr(EVEN, 8'h00);
    wr(EV, 8'h80);
    rdChk(EV, 8'h80);
    fifoNotEmpty <= 1'b0;
    rdChk(EV, 8'h00);
    fire(8'h03);
    rdChk(EV, 8'h28);
    wr(EV, 8'h30);
    rdChk(EV, 8'h08);
    wr(EV, 8'h08);
    $display("test clear and fifo done");
    fire(8'h04);
    rdChk(EV, 8'h02);
    fire(8'h08);
    rdChk(EV, 8'h06);
    wr(EV, 8'h06);
    fire(8'h04);
    fire(8'h10);
    chk({7'h0, discardPkt}, 8'h01);
    rdChk(EV, 8'h02);
    wr(EV, 8'h02);
    wr(SOPEN, 8'h1e);
    fire(8'h04);
    fire(8'h08);
    rdChk(EV, 8'h00);
    fireType <= 3'h1;
    fire(8'h04);
    fire(8'h08);
    rdChk(EV, 8'h06);
    wr(EV, 8'h06);
    fireType <= 3'h5;
    fire(8'h04);
    fire(8'h08);
    rdChk(EV, 8'h00);
    fireType <= 3'h0;
    wr(SOPEN, 8'h1f);
    $display("test framing done");
    for (int i = 0; i < 6; i++)
    begin
      mode <= caseIn[i][5:3];
      qual <= caseIn[i][2:0];
      fire(8'h20);
      chk({discardPkt, storePkt, replyStart, retryAbort, 4'h0}, {caseExp[i][7:4], 4'h0});
      rdChk(EV, {7'h0, caseExp[i][0]});
      rdChk(ER, {6'h0, caseExp[i][2:1]});
      wr(EV, 8'hff);
      wr(ER, 8'hff);
    end
    mode <= 3'h0;
    qual <= 3'h0;
    $display("test receive modes done");
    cause <= 4'h9;
    fire(8'h40);
    chk({4'h0, pktStatusSet}, 8'h09);
    rdChk(ER, 8'h08);
    chk({7'h0, irq}, 8'h00);
    wr(EREN, 8'h08);
    rdChk(EREN, 8'h08);
    chk({7'h0, irq}, 8'h01);
    wr(ER, 8'hff);
    rdChk(ER, 8'h00);
    chk({7'h0, irq}, 8'h00);
    wr(EREN, 8'h00);
    bufferFull <= 1'b1;
    fire(8'h80);
    chk({6'h0, fifoFullSet, discardPkt}, 8'h03);
    rdChk(ER, 8'h04);
    bufferFull <= 1'b0;
    wr(ER, 8'h04);
    badCrcLimit <= 1'b1;
    rdChk(ER, 8'h80);
    wr(ER, 8'h80);
    rdChk(ER, 8'h80);
    badCrcLimit <= 1'b0;
    wr(ER, 8'h80);
    rdChk(ER, 8'h00);
    dupLimit <= 1'b1;
    rdChk(ER, 8'h80);
    dupLimit <= 1'b0;
    wr(ER, 8'h80);
    $display("test errors done");
    fire(8'h02);
    chk({7'h0, irq}, 8'h00);
    wr(EVEN, 8'h08);
    rdChk(EV, 8'h08);
    chk({7'h0, irq}, 8'h01);
    wr(EVEN, 8'h00);
    wr(EV, 8'h08);
    lineIdle <= 1'b0;
    wr(EVEN, 8'h40);
    rdChk(EV, 8'h00);
    lineIdle <= 1'b1;
    rdChk(EV, 8'h40);
    chk({7'h0, irq}, 8'h01);
    wr(EV, 8'h40);
    clocksRunning <= 1'b0;
    lineIdle <= 1'b0;
    rdChk(EV, 8'h00);
    lineIdle <= 1'b1;
    rdChk(EV, 8'h00);
    wr(EVEN, 8'h00);
    clocksRunning <= 1'b1;
    rdChk(EV, 8'h00);
    wr(EVEN, 8'h40);
    rdChk(EV, 8'h40);
    $display("test idle and irq done");
    endSim();
  end
endmodule : pd_rx_event_status_bench
